// ### design/dual_io_sync_sram_parity.sv
// synchronous 32k x 9 dual-port sram with streaming and parity checker
`timescale 1ns/1ps
module dual_io_sync_sram_parity #(
   parameter int unsigned DEPTH   = sram_pkg::DEPTH,
   parameter int unsigned INDEX_W = sram_pkg::INDEX_W
) (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic      [31:0]                 hrdata,
   output logic                             hreadyout,
   output logic                             hresp,
   input  wire logic [INDEX_W-1:0]          word_index,
   input  wire logic                        select_low_n,
   input  wire logic                        select_high,
   input  wire logic                        store_strobe_n,
   input  wire logic                        cpu_port_capture_en_n,
   input  wire logic                        bus_port_capture_en_n,
   input  wire logic                        cpu_port_drive_en_n,
   input  wire logic                        bus_port_drive_en_n,
   input  wire logic [sram_pkg::DATA_W-1:0] cpu_port_data_in,
   input  wire logic                        cpu_port_check_bit_in,
   output logic      [sram_pkg::DATA_W-1:0] cpu_port_data_out,
   output logic                             cpu_port_check_bit_out,
   output logic                             cpu_port_oe_n,
   input  wire logic [sram_pkg::DATA_W-1:0] bus_port_data_in,
   input  wire logic                        bus_port_check_bit_in,
   output logic      [sram_pkg::DATA_W-1:0] bus_port_data_out,
   output logic                             bus_port_check_bit_out,
   output logic                             bus_port_oe_n,
   input  wire logic                        parity_fault_n_in,
   output logic                             parity_fault_n_out,
   output logic                             parity_fault_n_oe_n
);
   localparam int unsigned W = sram_pkg::WORD_W;

   logic [W-1:0]       mem [DEPTH];
   logic [INDEX_W-1:0] idx_reg;
   logic               sel_reg;
   logic [W-1:0]       cpu_out_reg;
   logic [W-1:0]       bus_out_reg;
   logic               cpu_may_drive_reg;
   logic               bus_may_drive_reg;
   logic [W-1:0]       ibus_word_reg;
   logic               read_valid_reg;
   logic               fault_oe_n_reg;
   logic               fault_out_reg;
   logic [sram_pkg::FCNT_W-1:0] fcnt_reg;
   logic [sram_pkg::FCNT_W-1:0] fcnt_next;
   sram_pkg::cycle_e   kind_reg;

   sram_pkg::cycle_e   cycle_kind;
   logic               cap_cpu;
   logic               cap_bus;
   logic [W-1:0]       cpu_in_word;
   logic [W-1:0]       bus_in_word;
   logic [W-1:0]       cap_word;
   logic [W-1:0]       ibus_word;
   logic               chk_en;
   logic               fcnt_clear;
   logic               fault_now;
   logic [31:0]        status_word;

   // even parity: a fault is a check bit that differs from the data xor
   function automatic logic parity_bad(input logic [W-1:0] wd);
      parity_bad = wd[sram_pkg::CHECK_BIT] != ^wd[sram_pkg::DATA_W-1:0];
   endfunction : parity_bad

   assign cap_cpu     = !cpu_port_capture_en_n;
   assign cap_bus     = !bus_port_capture_en_n;
   assign cpu_in_word = {cpu_port_check_bit_in, cpu_port_data_in};
   assign bus_in_word = {bus_port_check_bit_in, bus_port_data_in};
   // the pin value at the rising edge is the input register's content
   assign cap_word    = cap_cpu ? cpu_in_word : bus_in_word;

   // index and selects are registered on the falling edge
   always_ff @(negedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         idx_reg <= '0;
         sel_reg <= 1'b0;
      end else begin
         idx_reg <= word_index;
         sel_reg <= !select_low_n && select_high;
      end
   end

   // unlisted combinations all decode as CYC_NOP
   always_comb begin
      cycle_kind = sram_pkg::CYC_NOP;
      if (sel_reg) begin
         if (!cap_cpu && !cap_bus) begin
            if (store_strobe_n &&
                !(cpu_port_drive_en_n && bus_port_drive_en_n)) begin
               cycle_kind = sram_pkg::CYC_READ;
            end
         end else if (cap_cpu != cap_bus) begin
            cycle_kind = store_strobe_n ? sram_pkg::CYC_STREAM
                                        : sram_pkg::CYC_WRITE;
         end
      end
   end

   // internal bus carries the array word on reads, captured word otherwise
   always_comb begin
      ibus_word = cap_word;
      if (cycle_kind == sram_pkg::CYC_READ) begin
         ibus_word = mem[idx_reg];
      end
   end

   // self-timed write: committed at the same edge, no further strobe
   always_ff @(posedge hclk) begin
      if (cycle_kind == sram_pkg::CYC_WRITE) begin
         mem[idx_reg] <= cap_word;
      end
   end

   // output latches load at the rising edge, so they move only while high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_out_reg <= '0;
         bus_out_reg <= '0;
      end else begin
         case (cycle_kind)
            sram_pkg::CYC_READ: begin
               cpu_out_reg <= ibus_word;
               bus_out_reg <= ibus_word;
            end
            sram_pkg::CYC_WRITE, sram_pkg::CYC_STREAM: begin
               if (cap_bus) begin
                  cpu_out_reg <= ibus_word;
               end else begin
                  bus_out_reg <= ibus_word;
               end
            end
            default: begin
            end
         endcase
      end
   end

   // which port may drive; the actual drive is gated by the live enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_may_drive_reg <= 1'b0;
         bus_may_drive_reg <= 1'b0;
      end else begin
         case (cycle_kind)
            sram_pkg::CYC_READ: begin
               cpu_may_drive_reg <= 1'b1;
               bus_may_drive_reg <= 1'b1;
            end
            sram_pkg::CYC_WRITE, sram_pkg::CYC_STREAM: begin
               cpu_may_drive_reg <= cap_bus;
               bus_may_drive_reg <= cap_cpu;
            end
            default: begin
               cpu_may_drive_reg <= 1'b0;
               bus_may_drive_reg <= 1'b0;
            end
         endcase
      end
   end

   // the drive enables act without a clock; contention is the outside's
   // job to avoid, as a capturing port may still have its driver on here
   assign cpu_port_oe_n = cpu_port_drive_en_n
                          || !cpu_may_drive_reg;
   assign bus_port_oe_n = bus_port_drive_en_n
                          || !bus_may_drive_reg;

   assign cpu_port_data_out      = cpu_out_reg[sram_pkg::DATA_W-1:0];
   assign cpu_port_check_bit_out = cpu_out_reg[sram_pkg::CHECK_BIT];
   assign bus_port_data_out      = bus_out_reg[sram_pkg::DATA_W-1:0];
   assign bus_port_check_bit_out = bus_out_reg[sram_pkg::CHECK_BIT];

   // parity pipeline: bus word held one cycle, flag set at the next edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ibus_word_reg  <= '0;
         read_valid_reg <= 1'b0;
         kind_reg       <= sram_pkg::CYC_NOP;
      end else begin
         ibus_word_reg  <= ibus_word;
         read_valid_reg <= (cycle_kind == sram_pkg::CYC_READ) && chk_en;
         kind_reg       <= cycle_kind;
      end
   end

   assign fault_now = read_valid_reg && parity_bad(ibus_word_reg);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fault_oe_n_reg <= 1'b1;
         fault_out_reg  <= 1'b0;
      end else begin
         fault_oe_n_reg <= !fault_now;
         fault_out_reg  <= 1'b0;
      end
   end

   assign parity_fault_n_oe_n = fault_oe_n_reg;
   assign parity_fault_n_out  = fault_out_reg;

   // saturating fault count; a fault in the clear cycle is still counted
   always_comb begin
      fcnt_next = fcnt_clear ? '0 : fcnt_reg;
      if (fault_now && (fcnt_next != '1)) begin
         fcnt_next = fcnt_next + 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fcnt_reg <= '0;
      end else begin
         fcnt_reg <= fcnt_next;
      end
   end

   // the shared line is read back so software sees any device's fault
   always_comb begin
      status_word = 32'h0;
      status_word[sram_pkg::ST_SEL]   = sel_reg;
      status_word[sram_pkg::ST_FAULT] = !parity_fault_n_in;
      status_word[sram_pkg::ST_KIND_LSB +: 2] = kind_reg;
      status_word[sram_pkg::ST_IDX_LSB +: INDEX_W] = idx_reg;
   end

   sram_regs u_regs (
      .hclk        (hclk),
      .hresetn     (hresetn),
      .hsel        (hsel),
      .haddr       (haddr),
      .htrans      (htrans),
      .hwrite      (hwrite),
      .hsize       (hsize),
      .hwdata      (hwdata),
      .hready      (hready),
      .hrdata      (hrdata),
      .hreadyout   (hreadyout),
      .hresp       (hresp),
      .chk_en      (chk_en),
      .fcnt_clear  (fcnt_clear),
      .status_word (status_word),
      .fault_count (fcnt_reg)
   );

   // latch contents as the clock falls; the next rising edge must still
   // see them, so any move during the low phase shows up there
   logic [2*W-1:0] low_phase_reg;

   always_ff @(negedge hclk) begin
      low_phase_reg <= {cpu_out_reg, bus_out_reg};
   end

   // checks
   sequence s_bad_read;
      (cycle_kind == sram_pkg::CYC_READ) && chk_en && parity_bad(ibus_word);
   endsequence

   sequence s_good_or_idle;
      (cycle_kind != sram_pkg::CYC_READ) || !parity_bad(ibus_word);
   endsequence

   a_fault_lag_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_bad_read |-> ##1 read_valid_reg ##1 !fault_oe_n_reg)
      else $error("parity fault not flagged two edges after bad read");

   a_fault_idle_high: assert property (
      @(posedge hclk) disable iff (!hresetn)
      s_good_or_idle |-> ##2 fault_oe_n_reg)
      else $error("parity fault flagged without a bad read");

   a_standby_hiz: assert property (
      @(posedge hclk) disable iff (!hresetn)
      !sel_reg |=> !cpu_may_drive_reg && !bus_may_drive_reg && cpu_port_oe_n)
      else $error("port may drive while deselected");

   a_capture_port_hiz: assert property (
      @(posedge hclk) disable iff (!hresetn)
      cap_cpu |=> cpu_port_oe_n)
      else $error("capturing processor port drives its outputs");

   a_nop_releases: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sel_reg && cap_cpu && cap_bus |=>
         cpu_port_oe_n && bus_port_oe_n ##1 fault_oe_n_reg)
      else $error("no-cycle combination left a port or the flag active");

   a_write_stores: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cycle_kind == sram_pkg::CYC_WRITE) |=>
         mem[$past(idx_reg)] == $past(cap_word))
      else $error("written word not found in array");

   a_nowrite_keeps: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cycle_kind != sram_pkg::CYC_WRITE) |=>
         mem[$past(idx_reg)] === $past(mem[idx_reg]))
      else $error("array changed outside a write");

   a_read_presents: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (cycle_kind == sram_pkg::CYC_READ) |=>
         cpu_out_reg == $past(mem[idx_reg]) && cpu_may_drive_reg)
      else $error("read word not presented on processor port");

   a_stream_passes: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sel_reg && cap_bus && !cap_cpu |=>
         cpu_out_reg == $past(bus_in_word) && cpu_may_drive_reg
         && !bus_may_drive_reg)
      else $error("system word not streamed to processor port");

   a_stream_nostore: assert property (
      @(posedge hclk) disable iff (!hresetn)
      sel_reg && store_strobe_n && (cap_cpu != cap_bus) |=>
         mem[$past(idx_reg)] === $past(mem[idx_reg]))
      else $error("stream with strobe high stored a word");

   a_latch_steady_low: assert property (
      @(posedge hclk) disable iff (!hresetn)
      {cpu_out_reg, bus_out_reg} == low_phase_reg)
      else $error("output latch moved during clock low");
endmodule : dual_io_sync_sram_parity

// ### common/sram_pkg.sv
// shared constants for the synchronous dual-port parity sram
package sram_pkg;
   localparam int unsigned INDEX_W     = 15;
   localparam int unsigned DEPTH       = 32768;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned WORD_W      = 9;
   localparam int unsigned CHECK_BIT   = 8;
   localparam int unsigned FCNT_W      = 16;

   // register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_FCNT     = 8'h08;
   localparam int unsigned OFS_LSB     = 2;
   localparam int unsigned OFS_MSB     = 7;

   // control fields
   localparam int unsigned CTRL_CHK_EN = 0;
   localparam logic        CTRL_RESET  = 1'b1;

   // status fields
   localparam int unsigned ST_SEL      = 0;
   localparam int unsigned ST_FAULT    = 1;
   localparam int unsigned ST_KIND_LSB = 2;
   localparam int unsigned ST_IDX_LSB  = 16;

   // ahb-lite encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   // memory cycle kinds, gray along nop-read-write-stream
   typedef enum logic [1:0] {
      CYC_NOP    = 2'h0,
      CYC_READ   = 2'h1,
      CYC_WRITE  = 2'h3,
      CYC_STREAM = 2'h2
   } cycle_e;
endpackage : sram_pkg

// ### design/sram_regs.sv
// ahb-lite register slave for the parity sram
`timescale 1ns/1ps
module sram_regs (
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   output logic                              chk_en,
   output logic                              fcnt_clear,
   input  wire logic [31:0]                  status_word,
   input  wire logic [sram_pkg::FCNT_W-1:0]  fault_count
);
   logic       hrdata_reg;
   logic [31:0] rdata_reg;
   logic       wr_pend_reg;
   logic [7:0] wr_ofs_reg;
   logic       chk_en_reg;
   logic       clr_reg;
   logic       access;
   logic [7:0] ofs;

   function automatic logic [7:0] word_ofs(input logic [31:0] a);
      word_ofs = {a[sram_pkg::OFS_MSB:sram_pkg::OFS_LSB], 2'h0};
   endfunction : word_ofs

   assign access = hready & hsel & htrans[1];
   assign ofs    = word_ofs(haddr);

   // zero wait state: read data is prepared at the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_reg <= 32'h0;
      end else if (access && !hwrite) begin
         case (ofs)
            sram_pkg::OFS_CTRL:   rdata_reg <= {31'h0, chk_en_reg};
            sram_pkg::OFS_STATUS: rdata_reg <= status_word;
            sram_pkg::OFS_FCNT:   rdata_reg <= {16'h0, fault_count};
            default:              rdata_reg <= 32'h0;
         endcase
      end else if (hready) begin
         rdata_reg <= 32'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_ofs_reg  <= 8'h0;
      end else if (hready) begin
         wr_pend_reg <= access & hwrite & (hsize == 3'h2);
         wr_ofs_reg  <= ofs;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         chk_en_reg <= sram_pkg::CTRL_RESET;
         clr_reg    <= 1'b0;
      end else begin
         clr_reg <= wr_pend_reg && (wr_ofs_reg == sram_pkg::OFS_FCNT);
         if (wr_pend_reg && (wr_ofs_reg == sram_pkg::OFS_CTRL)) begin
            chk_en_reg <= hwdata[sram_pkg::CTRL_CHK_EN];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_reg <= 1'b1;
      end else begin
         hrdata_reg <= 1'b1;
      end
   end

   assign hrdata     = rdata_reg;
   assign hreadyout  = hrdata_reg;
   assign hresp      = sram_pkg::HRESP_OKAY;
   assign chk_en     = chk_en_reg;
   assign fcnt_clear = clr_reg;
endmodule : sram_regs

// ### verif/port_agents.sv
// far-side controllers: resolve both data ports and the shared fault line
`timescale 1ns/1ps
module port_agents (
   input  wire logic       hclk,
   input  wire logic [8:0] cpu_dev,
   input  wire logic       cpu_dev_oe_n,
   input  wire logic       cpu_drv,
   input  wire logic [8:0] cpu_word,
   input  wire logic [8:0] bus_dev,
   input  wire logic       bus_dev_oe_n,
   input  wire logic       bus_drv,
   input  wire logic [8:0] bus_word,
   input  wire logic       fault_out,
   input  wire logic       fault_oe_n,
   output logic      [8:0] cpu_pin,
   output logic      [8:0] bus_pin,
   output logic            fault_line
);
   logic [8:0] cpu_last;
   logic [8:0] bus_last;

   // a released port shows a word that flips every cycle, never a stale one
   always_comb begin
      cpu_pin = !cpu_dev_oe_n ? cpu_dev : cpu_drv ? cpu_word : ~cpu_last;
      bus_pin = !bus_dev_oe_n ? bus_dev : bus_drv ? bus_word : ~bus_last;
   end

   always_ff @(posedge hclk) begin
      cpu_last <= cpu_pin;
      bus_last <= bus_pin;
   end

   // pull-up on the wired line; only a low pull from a device shows
   assign fault_line = fault_oe_n ? 1'b1 : fault_out;
endmodule : port_agents

// ### verif/tb.sv
// self-checking bench for the dual-port parity sram
`timescale 1ns/1ps
module tb;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [14:0] word_index, ix;
   logic        select_low_n, select_high, store_strobe_n, chk_on;
   logic        cpu_port_capture_en_n, bus_port_capture_en_n;
   logic        cpu_port_drive_en_n, bus_port_drive_en_n;
   logic [7:0]  cpu_port_data_out, bus_port_data_out;
   logic        cpu_port_check_bit_out, bus_port_check_bit_out;
   logic        cpu_port_oe_n, bus_port_oe_n, parity_fault_n_out;
   logic        parity_fault_n_oe_n, fault_line, cpu_drv, bus_drv;
   logic [8:0]  cpu_pin, bus_pin, cpu_word, bus_word, w;
   logic [4:0]  ctl;
   logic [8:0]  mem [logic [14:0]];
   logic [14:0] idxq [$];
   logic [6:0]  nops [6] = '{7'h23, 7'h33, 7'h2f, 7'h3f, 7'h67, 7'h1d};
   int          err_total, n_tests, n_bad;

   dual_io_sync_sram_parity dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hrdata, .hreadyout, .hresp, .word_index,
      .select_low_n, .select_high, .store_strobe_n, .cpu_port_capture_en_n,
      .bus_port_capture_en_n, .cpu_port_drive_en_n, .bus_port_drive_en_n,
      .cpu_port_data_in(cpu_pin[7:0]), .cpu_port_check_bit_in(cpu_pin[8]),
      .cpu_port_data_out, .cpu_port_check_bit_out, .cpu_port_oe_n,
      .bus_port_data_in(bus_pin[7:0]), .bus_port_check_bit_in(bus_pin[8]),
      .bus_port_data_out, .bus_port_check_bit_out, .bus_port_oe_n,
      .parity_fault_n_in(fault_line), .parity_fault_n_out,
      .parity_fault_n_oe_n
   );

   port_agents agents (
      .hclk, .cpu_dev({cpu_port_check_bit_out, cpu_port_data_out}),
      .cpu_dev_oe_n(cpu_port_oe_n), .cpu_drv, .cpu_word,
      .bus_dev({bus_port_check_bit_out, bus_port_data_out}),
      .bus_dev_oe_n(bus_port_oe_n), .bus_drv, .bus_word,
      .fault_out(parity_fault_n_out), .fault_oe_n(parity_fault_n_oe_n),
      .cpu_pin, .bus_pin, .fault_line
   );

   always #25 hclk = ~hclk;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   function automatic logic good_par(input logic [8:0] v);
      return v[8] == ^v[7:0];
   endfunction : good_par

   task automatic chk_w(input logic [8:0] got, input logic [8:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_w

   task automatic chk_r(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_r

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : conclude

   // one single word transfer; entered right after a rising edge
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] q);
      int n;
      hsel <= 1'b1;
      htrans <= sram_pkg::HTRANS_NONSEQ;
      hsize <= 3'h2;
      haddr <= {24'h0, a};
      hwrite <= wr;
      for (int p = 0; p < 2; p++) begin
         n = 0;
         do begin
            @(posedge hclk);
            n++;
         end while (hreadyout !== 1'b1 && n < 16);
         if (hreadyout !== 1'b1) begin
            err_total++;
            conclude();
         end
         if (p == 0) begin
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= wd;
         end
      end
      q = hrdata;
      chk_w(hresp, sram_pkg::HRESP_OKAY);
   endtask : ahb

   // one memory cycle, an idle cycle to look at it, and one for the flag
   task automatic cyc(input logic [14:0] a, input logic [1:0] sel,
                      input logic [4:0] c, input logic [8:0] d,
                      input logic drop);
      logic [8:0] rw;
      logic       on, rdc, one, ec, eb, ef;
      {store_strobe_n, cpu_port_capture_en_n, bus_port_capture_en_n,
       cpu_port_drive_en_n, bus_port_drive_en_n} <= c;
      {select_low_n, select_high} <= sel;
      word_index <= a;
      cpu_drv <= !c[3];
      bus_drv <= !c[2];
      cpu_word <= d;
      bus_word <= d;
      on = sel == 2'b01;
      rdc = on && c[4:2] == 3'b111 && c[1:0] != 2'b11;
      one = on && c[3] != c[2];
      rw = rdc ? mem[a] : d;
      ec = !((rdc || (one && !c[2])) && !c[1]);
      eb = !((rdc || (one && !c[3])) && !c[0]);
      ef = rdc && chk_on ? good_par(rw) : 1'b1;
      if (one && !c[4])
         mem[a] = d;
      @(posedge hclk);
      // strobe low with no capture is a no-op, so nothing repeats
      store_strobe_n <= 1'b0;
      {cpu_port_capture_en_n, bus_port_capture_en_n} <= 2'h3;
      {cpu_drv, bus_drv} <= 2'h0;
      if (drop)
         cpu_port_drive_en_n <= 1'b1;
      @(negedge hclk);
      chk_w(cpu_port_oe_n, ec | drop);
      chk_w(bus_port_oe_n, eb);
      if (!ec && !drop)
         chk_w(cpu_pin, rw);
      if (!eb)
         chk_w(bus_pin, rw);
      chk_w(fault_line, 1'b1);
      @(posedge hclk);
      @(negedge hclk);
      chk_w(fault_line, ef);
      if (!ef)
         n_bad++;
      @(posedge hclk);
   endtask : cyc

   initial begin
      {hclk, hresetn, hsel, hwrite, htrans, hsize} = 9'h002;
      {haddr, hwdata, word_index} = '0;
      {select_low_n, select_high, store_strobe_n} = 3'h5;
      {cpu_port_capture_en_n, bus_port_capture_en_n} = 2'h3;
      {cpu_port_drive_en_n, bus_port_drive_en_n} = 2'h3;
      {cpu_drv, bus_drv, cpu_word, bus_word} = '0;
      {err_total, n_tests, n_bad} = '0;
      seed = 32'h2;
      chk_on = 1'b1;
      repeat (3) @(posedge hclk);
      chk_w({cpu_port_oe_n, bus_port_oe_n, fault_line}, 9'h7);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, sram_pkg::OFS_CTRL, 32'h0, rd);
      chk_r(rd, 32'h1);
      ahb(1'b1, 8'h0c, 32'hffff_ffff, rd);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk_r(rd, 32'h0);
      // writes from both sides, corner indices first, the far port random
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         ix = i == 0 ? 15'h0 : i == 1 ? 15'h7fff : seed[14:0];
         w = seed[24:16];
         if (i < 2)
            w[8] = (^w[7:0]) ^ (i == 0);
         ctl = i[0] ? {3'b010, seed[30], 1'b1} : {3'b001, 1'b1, seed[30]};
         cyc(ix, 2'b01, ctl, w, 1'b0);
         idxq.push_back(ix);
      end
      foreach (idxq[k]) begin
         seed = xs(seed);
         ctl = {3'b111, seed[1:0] == 2'b11 ? 2'b00 : seed[1:0]};
         cyc(idxq[k], 2'b01, ctl, 9'h0, 1'b0);
      end
      seed = xs(seed);
      cyc(15'h0, 2'b01, 5'b11001, seed[8:0], 1'b0);
      foreach (nops[k]) begin
         cyc(15'h0, nops[k][6:5], nops[k][4:0], seed[8:0], 1'b0);
         cyc(15'h0, 2'b01, 5'b11101, 9'h0, 1'b0);
      end
      cyc(idxq[1], 2'b01, 5'b11100, 9'h0, 1'b1);
      ahb(1'b0, sram_pkg::OFS_FCNT, 32'h0, rd);
      chk_r(rd, 32'(n_bad));
      ahb(1'b0, sram_pkg::OFS_STATUS, 32'h0, rd);
      chk_r(rd, {1'b0, idxq[1], 16'h0001});
      ahb(1'b1, sram_pkg::OFS_CTRL, 32'h0, rd);
      chk_on = 1'b0;
      cyc(15'h0, 2'b01, 5'b11101, 9'h0, 1'b0);
      conclude();
   end
endmodule : tb
